// *** design/fbm_params.svh ***
// Constants for the bus-matching and reset-configuration block
// Behaviour
// - Inbound queue takes only whole long words
// - Final receive piece commits whole long word
// - Byte width ignores receive data bits nine up
// - Word receive halves ordered by endian choice
// - Byte receive lanes ordered by endian choice
// - Word transmit halves ordered by endian choice
// - Endian fixed at reset; widths held static
// - Transmit empty drops earlier when timing high
// - Port A empty drops earlier when timing high
// - Parallel offset load by port A writes
// - Queue writes ignored until full flags high
// - Serial offsets arrive in fixed four-field order
// - Master reset can preset offsets to eight
// - Byte transmit lanes ordered by endian choice
// - Endian level sampled at master reset release
// - Outbound read whole; remainder held in staging
`ifndef FBM_PARAMS_SVH
`define FBM_PARAMS_SVH

// ****************************************************************
// Offset preset and programming
// ****************************************************************
`define FBM_PRESET_OFS 8
`define FBM_MODE_PRESET 2'h0
`define FBM_MODE_PARALLEL 2'h1
`define FBM_MODE_SERIAL 2'h2
`define FBM_OFS_LAST 2'h3
`define FBM_OFS_OB_AFULL 0
`define FBM_OFS_OB_AEMPTY 1
`define FBM_OFS_IB_AFULL 2
`define FBM_OFS_IB_AEMPTY 3

// ****************************************************************
// Piece positions within a long word
// ****************************************************************
`define FBM_LAST_BYTE 2'h3
`define FBM_LAST_WORD 2'h1
`define FBM_POS_FIRST 2'h0

`endif

// *** design/fbm_pkg.sv ***
// Types shared by the bus-matching block
package fbm_pkg;
  typedef enum logic [1:0] {ST_CFG, ST_PROG, ST_RUN} fbm_state_t;
  typedef enum logic [1:0] {PRG_PRESET, PRG_PARALLEL, PRG_SERIAL} fbm_prog_t;
endpackage

// *** design/fbm_queue.sv ***
// Long-word queue memory with pointers and fill count
`timescale 1ns/1ps
module fbm_queue import fbm_pkg::*; #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 2048,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic clear_in,
  input wire logic wr_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic rd_in,
  output logic [WIDTH-1:0] rd_data_out,
  output logic [AW:0] count_out,
  output logic full_out,
  output logic empty_out
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  logic do_wr;
  logic do_rd;

  assign full_out = (count_ff == (AW+1)'(DEPTH));
  assign empty_out = (count_ff == '0);
  assign do_wr = wr_in & ~full_out & ~clear_in;
  assign do_rd = rd_in & ~empty_out & ~clear_in;
  assign rd_data_out = mem[rd_ptr_ff];
  assign count_out = count_ff;

  always_ff @(posedge clk_in) begin
    if (do_wr) begin
      mem[wr_ptr_ff] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else if (clear_in) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
      if (do_wr && !do_rd) begin
        count_ff <= count_ff + 1'b1;
      end else if (do_rd && !do_wr) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end
endmodule

// *** design/fbm_top.sv ***
// Bus matching, reset configuration and offset loading for two queues
`timescale 1ns/1ps
`include "fbm_params.svh"
module fbm_top import fbm_pkg::*; #(
  parameter int DEPTH = 2048,
  parameter int CW = $clog2(DEPTH) + 1
) (
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic OUTBOUND_FULL_RESET_N_IN,
  input wire logic INBOUND_FULL_RESET_N_IN,
  input wire logic OUTBOUND_PARTIAL_RESET_N_IN,
  input wire logic INBOUND_PARTIAL_RESET_N_IN,
  input wire logic ENDIAN_TIMING_SELECT_IN,
  input wire logic TRANSMIT_WIDTH_SELECT_IN,
  input wire logic RECEIVE_WIDTH_SELECT_IN,
  input wire logic [1:0] OFFSET_MODE_SELECT_IN,
  input wire logic SERIAL_OFFSET_INPUT_IN,
  input wire logic SERIAL_LOAD_ENABLE_IN,
  input wire logic PORT_A_CHIP_SELECT_N_IN,
  input wire logic PORT_A_DIRECTION_IN,
  input wire logic PORT_A_ENABLE_IN,
  input wire logic PORT_A_MAILBOX_SELECT_IN,
  input wire logic [35:0] PORT_A_DATA_IN,
  output logic [35:0] PORT_A_DATA_OUT,
  output logic PORT_A_DATA_OE_OUT,
  input wire logic RECEIVE_WRITE_ENABLE_IN,
  input wire logic RECEIVE_MAILBOX_SELECT_IN,
  input wire logic [17:0] RECEIVE_DATA_IN,
  input wire logic TRANSMIT_READ_ENABLE_IN,
  output logic [17:0] TRANSMIT_DATA_OUT,
  output logic PORT_A_FULL_OR_IN_READY_OUT,
  output logic RECEIVE_FULL_OR_IN_READY_OUT,
  output logic TRANSMIT_EMPTY_OR_OUT_READY_OUT,
  output logic PORT_A_EMPTY_OR_OUT_READY_OUT,
  output logic PORT_A_ALMOST_FULL_FLAG_N_OUT,
  output logic TRANSMIT_ALMOST_EMPTY_FLAG_N_OUT,
  output logic RECEIVE_ALMOST_FULL_FLAG_N_OUT,
  output logic PORT_A_ALMOST_EMPTY_FLAG_N_OUT
);
  // ****************************************************************
  // Helpers
  // ****************************************************************
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

  function automatic logic [1:0] lane_sel(input logic big,
                                          input logic [1:0] pos);
    lane_sel = big ? pos : (2'h3 - pos);
  endfunction

  function automatic logic [1:0] last_pos(input logic byte_mode);
    last_pos = byte_mode ? `FBM_LAST_BYTE : `FBM_LAST_WORD;
  endfunction

  function automatic logic [17:0] tx_piece(input logic [35:0] w,
                                           input logic [1:0] pos,
                                           input logic byte_mode,
                                           input logic big);
    logic [1:0] lane;
    logic lower;
    lane = lane_sel(big, pos);
    lower = big ? pos[0] : ~pos[0];
    tx_piece = 18'h00000;
    if (byte_mode) begin
      case (lane)
        2'h0: tx_piece[8:0] = w[35:27];
        2'h1: tx_piece[8:0] = w[26:18];
        2'h2: tx_piece[8:0] = w[17:9];
        default: tx_piece[8:0] = w[8:0];
      endcase
    end else if (lower) begin
      tx_piece = w[17:0];
    end else begin
      tx_piece = w[35:18];
    end
  endfunction

  function automatic logic [35:0] rx_place(input logic [35:0] acc,
                                           input logic [17:0] d,
                                           input logic [1:0] pos,
                                           input logic byte_mode,
                                           input logic big);
    logic [1:0] lane;
    logic lower;
    lane = lane_sel(big, pos);
    lower = big ? pos[0] : ~pos[0];
    rx_place = acc;
    if (byte_mode) begin
      case (lane)
        2'h0: rx_place[35:27] = d[8:0];
        2'h1: rx_place[26:18] = d[8:0];
        2'h2: rx_place[17:9] = d[8:0];
        default: rx_place[8:0] = d[8:0];
      endcase
    end else if (lower) begin
      rx_place[17:0] = d;
    end else begin
      rx_place[35:18] = d;
    end
  endfunction

  function automatic logic afull_hit(input logic [CW-1:0] cnt,
                                     input logic [CW-1:0] ofs);
    afull_hit = (cnt >= (DEPTH_C - ofs));
  endfunction

  function automatic logic aempty_hit(input logic [CW-1:0] cnt,
                                      input logic [CW-1:0] ofs);
    aempty_hit = (cnt <= ofs);
  endfunction

  // ****************************************************************
  // Declarations
  // ****************************************************************
  fbm_state_t state_ff;
  fbm_prog_t mode_ff;
  fbm_prog_t nxt_mode;
  logic big_ff;
  logic tx_byte_ff;
  logic rx_byte_ff;
  logic mrs_low_d_ff;
  logic ob_clr_d_ff;
  logic ib_clr_d_ff;
  logic [CW-1:0] ofs_ff [4];
  logic [1:0] prog_idx_ff;
  logic [CW-1:0] bit_cnt_ff;
  logic [35:0] tx_word_ff;
  logic [1:0] tx_pos_ff;
  logic tx_have_ff;
  logic [35:0] rx_acc_ff;
  logic [1:0] rx_pos_ff;
  logic mrs_active;
  logic mrs_rise;
  logic ob_clr;
  logic ib_clr;
  logic run;
  logic pa_sel;
  logic pa_wr;
  logic pa_rd;
  logic prog_step;
  logic prog_word_done;
  logic prog_done;
  logic ob_wr;
  logic ob_rd;
  logic ib_wr;
  logic ib_rd;
  logic tx_ready;
  logic tx_take;
  logic tx_last;
  logic rx_take;
  logic rx_last;
  logic [35:0] tx_src;
  logic [35:0] nxt_rx_word;
  logic [35:0] ob_rd_data;
  logic [35:0] ib_rd_data;
  logic [CW-1:0] ob_count;
  logic [CW-1:0] ib_count;
  logic ob_full;
  logic ob_empty;
  logic ib_full;
  logic ib_empty;

  // ****************************************************************
  // Reset and configuration capture
  // ****************************************************************
  assign mrs_active = ~OUTBOUND_FULL_RESET_N_IN | ~INBOUND_FULL_RESET_N_IN;
  assign mrs_rise = mrs_low_d_ff & ~mrs_active;
  assign ob_clr = ~OUTBOUND_FULL_RESET_N_IN | ~OUTBOUND_PARTIAL_RESET_N_IN;
  assign ib_clr = ~INBOUND_FULL_RESET_N_IN | ~INBOUND_PARTIAL_RESET_N_IN;
  assign run = (state_ff == ST_RUN);

  always_comb begin
    case (OFFSET_MODE_SELECT_IN)
      `FBM_MODE_PARALLEL: nxt_mode = PRG_PARALLEL;
      `FBM_MODE_SERIAL: nxt_mode = PRG_SERIAL;
      default: nxt_mode = PRG_PRESET;
    endcase
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      mrs_low_d_ff <= 1'b0;
      ob_clr_d_ff <= 1'b0;
      ib_clr_d_ff <= 1'b0;
    end else begin
      mrs_low_d_ff <= mrs_active;
      ob_clr_d_ff <= ob_clr;
      ib_clr_d_ff <= ib_clr;
    end
  end

  // Endian and widths are latched at each master reset release; later motion of the endian pin still sets empty-flag timing
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      big_ff <= 1'b1;
      tx_byte_ff <= 1'b0;
      rx_byte_ff <= 1'b0;
      mode_ff <= PRG_PRESET;
    end else if (mrs_rise) begin
      big_ff <= ENDIAN_TIMING_SELECT_IN;
      tx_byte_ff <= TRANSMIT_WIDTH_SELECT_IN;
      rx_byte_ff <= RECEIVE_WIDTH_SELECT_IN;
      mode_ff <= nxt_mode;
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      state_ff <= ST_CFG;
    end else if (mrs_active) begin
      state_ff <= ST_CFG;
    end else begin
      case (state_ff)
        ST_CFG: begin
          if (mrs_rise) begin
            state_ff <= (nxt_mode == PRG_PRESET) ? ST_RUN : ST_PROG;
          end
        end
        ST_PROG: begin
          if (prog_done) begin
            state_ff <= ST_RUN;
          end
        end
        ST_RUN: state_ff <= ST_RUN;
        default: state_ff <= ST_CFG;
      endcase
    end
  end

  // ****************************************************************
  // Offset registers
  // ****************************************************************
  assign pa_sel = ~PORT_A_CHIP_SELECT_N_IN & PORT_A_ENABLE_IN &
                  ~PORT_A_MAILBOX_SELECT_IN;
  assign pa_wr = pa_sel & PORT_A_DIRECTION_IN;
  assign pa_rd = pa_sel & ~PORT_A_DIRECTION_IN;
  assign prog_step = (state_ff == ST_PROG) &&
                     (((mode_ff == PRG_PARALLEL) && pa_wr) ||
                      ((mode_ff == PRG_SERIAL) && SERIAL_LOAD_ENABLE_IN));
  assign prog_word_done = (mode_ff == PRG_PARALLEL) ||
                          (bit_cnt_ff == CW'(CW - 1));
  assign prog_done = prog_step && prog_word_done &&
                     (prog_idx_ff == `FBM_OFS_LAST);

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      for (int i = 0; i < 4; i++) begin
        ofs_ff[i] <= CW'(`FBM_PRESET_OFS);
      end
      prog_idx_ff <= 2'h0;
      bit_cnt_ff <= '0;
    end else if (mrs_rise) begin
      for (int i = 0; i < 4; i++) begin
        ofs_ff[i] <= (nxt_mode == PRG_PRESET) ?
                     CW'(`FBM_PRESET_OFS) : '0;
      end
      prog_idx_ff <= 2'h0;
      bit_cnt_ff <= '0;
    end else if (prog_step) begin
      if (mode_ff == PRG_PARALLEL) begin
        ofs_ff[prog_idx_ff] <= PORT_A_DATA_IN[CW-1:0];
      end else begin
        ofs_ff[prog_idx_ff] <= {ofs_ff[prog_idx_ff][CW-2:0],
                                SERIAL_OFFSET_INPUT_IN};
      end
      if (prog_word_done) begin
        prog_idx_ff <= prog_idx_ff + 1'b1;
        bit_cnt_ff <= '0;
      end else begin
        bit_cnt_ff <= bit_cnt_ff + 1'b1;
      end
    end
  end

  // ****************************************************************
  // Queues
  // ****************************************************************
  // Port A moves whole long words with no reordering
  assign ob_wr = pa_wr & PORT_A_FULL_OR_IN_READY_OUT;
  assign ib_rd = pa_rd & run & ~ib_clr & ~ib_empty;

  fbm_queue #(.WIDTH(36), .DEPTH(DEPTH)) u_outbound (
    .clk_in(CLK_IN),
    .rst_in(RST_IN),
    .clear_in(ob_clr),
    .wr_in(ob_wr),
    .wr_data_in(PORT_A_DATA_IN),
    .rd_in(ob_rd),
    .rd_data_out(ob_rd_data),
    .count_out(ob_count),
    .full_out(ob_full),
    .empty_out(ob_empty)
  );

  fbm_queue #(.WIDTH(36), .DEPTH(DEPTH)) u_inbound (
    .clk_in(CLK_IN),
    .rst_in(RST_IN),
    .clear_in(ib_clr),
    .wr_in(ib_wr),
    .wr_data_in(nxt_rx_word),
    .rd_in(ib_rd),
    .rd_data_out(ib_rd_data),
    .count_out(ib_count),
    .full_out(ib_full),
    .empty_out(ib_empty)
  );

  // ****************************************************************
  // Transmit unpacking
  // ****************************************************************
  assign tx_ready = tx_have_ff | ~ob_empty;
  assign tx_take = TRANSMIT_READ_ENABLE_IN & tx_ready & run & ~ob_clr;
  assign ob_rd = tx_take & ~tx_have_ff;
  assign tx_src = tx_have_ff ? tx_word_ff : ob_rd_data;
  assign tx_last = (tx_pos_ff == last_pos(tx_byte_ff));

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      tx_word_ff <= 36'h000000000;
      tx_pos_ff <= `FBM_POS_FIRST;
      tx_have_ff <= 1'b0;
      TRANSMIT_DATA_OUT <= 18'h00000;
    end else if (ob_clr) begin
      tx_pos_ff <= `FBM_POS_FIRST;
      tx_have_ff <= 1'b0;
    end else if (tx_take) begin
      TRANSMIT_DATA_OUT <= tx_piece(tx_src, tx_pos_ff, tx_byte_ff, big_ff);
      tx_word_ff <= tx_src;
      tx_have_ff <= ~tx_last;
      tx_pos_ff <= tx_last ? `FBM_POS_FIRST : tx_pos_ff + 1'b1;
    end
  end

  // ****************************************************************
  // Receive packing
  // ****************************************************************
  assign rx_take = RECEIVE_WRITE_ENABLE_IN & ~RECEIVE_MAILBOX_SELECT_IN &
                   RECEIVE_FULL_OR_IN_READY_OUT;
  assign rx_last = (rx_pos_ff == last_pos(rx_byte_ff));
  assign nxt_rx_word = rx_place(rx_acc_ff, RECEIVE_DATA_IN, rx_pos_ff,
                                rx_byte_ff, big_ff);
  assign ib_wr = rx_take & rx_last;

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      rx_acc_ff <= 36'h000000000;
      rx_pos_ff <= `FBM_POS_FIRST;
    end else if (ib_clr) begin
      rx_acc_ff <= 36'h000000000;
      rx_pos_ff <= `FBM_POS_FIRST;
    end else if (rx_take) begin
      rx_acc_ff <= rx_last ? 36'h000000000 : nxt_rx_word;
      rx_pos_ff <= rx_last ? `FBM_POS_FIRST : rx_pos_ff + 1'b1;
    end
  end

  // ****************************************************************
  // Port A data and flags
  // ****************************************************************
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      PORT_A_DATA_OUT <= 36'h000000000;
      PORT_A_DATA_OE_OUT <= 1'b0;
    end else begin
      PORT_A_DATA_OE_OUT <= ~PORT_A_CHIP_SELECT_N_IN & ~PORT_A_DIRECTION_IN;
      if (ib_rd) begin
        PORT_A_DATA_OUT <= ib_rd_data;
      end
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      PORT_A_FULL_OR_IN_READY_OUT <= 1'b0;
      RECEIVE_FULL_OR_IN_READY_OUT <= 1'b0;
      TRANSMIT_EMPTY_OR_OUT_READY_OUT <= 1'b0;
      PORT_A_EMPTY_OR_OUT_READY_OUT <= 1'b0;
    end else begin
      PORT_A_FULL_OR_IN_READY_OUT <= run & ~ob_clr & ~ob_full;
      RECEIVE_FULL_OR_IN_READY_OUT <= run & ~ib_clr & ~ib_full;
      // High timing select drops the flag one cycle sooner
      TRANSMIT_EMPTY_OR_OUT_READY_OUT <= tx_ready &
        ~((ob_clr & ENDIAN_TIMING_SELECT_IN) |
          (ob_clr_d_ff & ~ENDIAN_TIMING_SELECT_IN));
      PORT_A_EMPTY_OR_OUT_READY_OUT <= ~ib_empty &
        ~((ib_clr & ENDIAN_TIMING_SELECT_IN) |
          (ib_clr_d_ff & ~ENDIAN_TIMING_SELECT_IN));
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      PORT_A_ALMOST_FULL_FLAG_N_OUT <= 1'b1;
      TRANSMIT_ALMOST_EMPTY_FLAG_N_OUT <= 1'b0;
      RECEIVE_ALMOST_FULL_FLAG_N_OUT <= 1'b1;
      PORT_A_ALMOST_EMPTY_FLAG_N_OUT <= 1'b0;
    end else begin
      PORT_A_ALMOST_FULL_FLAG_N_OUT <=
        ~afull_hit(ob_count, ofs_ff[`FBM_OFS_OB_AFULL]);
      TRANSMIT_ALMOST_EMPTY_FLAG_N_OUT <=
        ~aempty_hit(ob_count, ofs_ff[`FBM_OFS_OB_AEMPTY]);
      RECEIVE_ALMOST_FULL_FLAG_N_OUT <=
        ~afull_hit(ib_count, ofs_ff[`FBM_OFS_IB_AFULL]);
      PORT_A_ALMOST_EMPTY_FLAG_N_OUT <=
        ~aempty_hit(ib_count, ofs_ff[`FBM_OFS_IB_AEMPTY]);
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking dflt_cb @(posedge CLK_IN);
  endclocking
  default disable iff (RST_IN);

  sequence ob_reset_slow_s;
    (ob_clr && !ENDIAN_TIMING_SELECT_IN) [*2];
  endsequence

  sequence ib_reset_slow_s;
    (ib_clr && !ENDIAN_TIMING_SELECT_IN) [*2];
  endsequence

  rx_commit_a: assert property (ib_wr && !ib_clr && ib_empty |=>
    !ib_empty && ib_rd_data == $past(nxt_rx_word))
    else $error("last receive piece did not commit");
  rx_whole_a: assert property (ib_wr |-> rx_take && rx_last)
    else $error("inbound write without full long word");
  byte_high_a: assert property (rx_take && rx_byte_ff && big_ff &&
    !ib_clr && rx_pos_ff == 2'h0 |=> rx_acc_ff[26:0] == 27'h0000000)
    else $error("byte write touched other lanes");
  byte_lane_a: assert property (rx_take && rx_byte_ff && big_ff &&
    !ib_clr && rx_pos_ff == 2'h0 |=>
    rx_acc_ff[35:27] == $past(RECEIVE_DATA_IN[8:0]))
    else $error("big-endian first byte misplaced");
  word_order_a: assert property (rx_take && !rx_byte_ff && !big_ff &&
    !ib_clr && rx_pos_ff == 2'h0 |=>
    rx_acc_ff[17:0] == $past(RECEIVE_DATA_IN))
    else $error("little-endian first word misplaced");
  tx_word_a: assert property (ob_rd && !tx_byte_ff && big_ff |=>
    TRANSMIT_DATA_OUT == $past(ob_rd_data[35:18]))
    else $error("big-endian first word read wrong");
  tx_byte_a: assert property (ob_rd && tx_byte_ff && !big_ff |=>
    TRANSMIT_DATA_OUT[8:0] == $past(ob_rd_data[8:0]))
    else $error("little-endian first byte read wrong");
  tx_stage_a: assert property (ob_rd |=> tx_have_ff &&
    tx_word_ff == $past(ob_rd_data))
    else $error("long word remainder not held");
  endian_latch_a: assert property (mrs_rise |=>
    big_ff == $past(ENDIAN_TIMING_SELECT_IN))
    else $error("endian not latched at reset release");
  preset_ofs_a: assert property (mrs_rise && nxt_mode == PRG_PRESET |=>
    ofs_ff[0] == CW'(8) && ofs_ff[3] == CW'(8))
    else $error("offsets not preset to eight");
  write_gate_a: assert property (!PORT_A_FULL_OR_IN_READY_OUT |=>
    ob_count <= $past(ob_count))
    else $error("queue write taken before flag high");
  ob_fast_a: assert property (ob_clr && ENDIAN_TIMING_SELECT_IN |=>
    !TRANSMIT_EMPTY_OR_OUT_READY_OUT)
    else $error("transmit empty flag not dropped early");
  ob_slow_a: assert property (ob_reset_slow_s |=>
    !TRANSMIT_EMPTY_OR_OUT_READY_OUT)
    else $error("transmit empty flag not dropped late");
  ib_slow_a: assert property (ib_reset_slow_s |=>
    !PORT_A_EMPTY_OR_OUT_READY_OUT)
    else $error("port A empty flag not dropped late");
  stage_clear_a: assert property (ob_clr || ib_clr |=>
    (!$past(ob_clr) || !tx_have_ff) && (!$past(ib_clr) || rx_pos_ff == 2'h0))
    else $error("staging not cleared by queue reset");
endmodule

// *** verification/fbm_reset_ctl.sv ***
// Reset controller model standing on the far side of the queue block
`timescale 1ns/1ps
module fbm_reset_ctl (
  input wire logic clk_in,
  input wire logic start_in,
  input wire logic partial_in,
  input wire logic port_a_ready_in,
  input wire logic receive_ready_in,
  output logic full_reset_n_out,
  output logic partial_reset_n_out,
  output logic mailbox_select_out
);
  logic [1:0] hold_ff;
  initial begin
    full_reset_n_out = 1'b1;
    mailbox_select_out = 1'b1;
    hold_ff = 2'h0;
  end
  assign partial_reset_n_out = ~(partial_in & full_reset_n_out);
  // One master level feeds both queues
  always @(posedge clk_in) begin
    if (start_in) begin
      full_reset_n_out <= 1'b0;
      mailbox_select_out <= 1'b1;
      hold_ff <= 2'h2;
    end else if (hold_ff != 2'h0) begin
      hold_ff <= hold_ff - 2'h1;
      full_reset_n_out <= (hold_ff == 2'h1);
    end else if (port_a_ready_in && receive_ready_in) begin
      mailbox_select_out <= 1'b0;
    end
  end
endmodule

// *** verification/tb.sv ***
// Self-checking bench for the bus-matching block
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0, rst = 1'b1, start = 1'b0, part = 1'b0, ets = 1'b1;
  logic txw = 1'b0, rxw = 1'b0, sdi = 1'b0, sle = 1'b0, cs_n = 1'b1;
  logic dir = 1'b0, en = 1'b0, rwe = 1'b0, tre = 1'b0, be, b;
  logic [1:0] mode = 2'h0;
  logic [35:0] pad = 36'h0;
  logic [17:0] rdat = 18'h0, tx_q;
  logic mr_n, pr_n, receive_mailbox_select, pa_rdy, rx_rdy, tx_emp, pa_emp, oe, tx_ae_n;
  logic pa_af_n, rx_af_n, pa_ae_n, port_a_mailbox_select = 1'b0;
  logic [35:0] pa_q;
  int err_total = 0, checked = 0, r, i, m;
  localparam logic [35:0] LW = 36'h9a5c3b1e7;
  localparam logic [35:0] OFS = 36'h10441;
  logic [19:0] rows [4] = '{{2'h2, 18'h26970}, {2'h0, 18'h3b1e7},
    {2'h3, 18'h00134}, {2'h1, 18'h001e7}};
  initial forever #25 clk = ~clk;
  fbm_reset_ctl u_ctl (.clk_in(clk), .start_in(start), .partial_in(part),
    .port_a_ready_in(pa_rdy), .receive_ready_in(rx_rdy),
    .full_reset_n_out(mr_n), .partial_reset_n_out(pr_n),
    .mailbox_select_out(receive_mailbox_select));
  fbm_top #(.DEPTH(16)) DUT (.CLK_IN(clk), .RST_IN(rst),
    .OUTBOUND_FULL_RESET_N_IN(mr_n), .INBOUND_FULL_RESET_N_IN(mr_n),
    .OUTBOUND_PARTIAL_RESET_N_IN(pr_n), .INBOUND_PARTIAL_RESET_N_IN(pr_n),
    .ENDIAN_TIMING_SELECT_IN(ets), .TRANSMIT_WIDTH_SELECT_IN(txw),
    .RECEIVE_WIDTH_SELECT_IN(rxw), .OFFSET_MODE_SELECT_IN(mode),
    .SERIAL_OFFSET_INPUT_IN(sdi), .SERIAL_LOAD_ENABLE_IN(sle),
    .PORT_A_CHIP_SELECT_N_IN(cs_n), .PORT_A_DIRECTION_IN(dir),
    .PORT_A_ENABLE_IN(en), .PORT_A_MAILBOX_SELECT_IN(port_a_mailbox_select),
    .PORT_A_DATA_IN(pad), .PORT_A_DATA_OUT(pa_q), .PORT_A_DATA_OE_OUT(oe),
    .RECEIVE_WRITE_ENABLE_IN(rwe), .RECEIVE_MAILBOX_SELECT_IN(receive_mailbox_select),
    .RECEIVE_DATA_IN(rdat), .TRANSMIT_READ_ENABLE_IN(tre),
    .TRANSMIT_DATA_OUT(tx_q), .PORT_A_FULL_OR_IN_READY_OUT(pa_rdy),
    .RECEIVE_FULL_OR_IN_READY_OUT(rx_rdy),
    .TRANSMIT_EMPTY_OR_OUT_READY_OUT(tx_emp),
    .PORT_A_EMPTY_OR_OUT_READY_OUT(pa_emp),
    .PORT_A_ALMOST_FULL_FLAG_N_OUT(pa_af_n),
    .TRANSMIT_ALMOST_EMPTY_FLAG_N_OUT(tx_ae_n),
    .RECEIVE_ALMOST_FULL_FLAG_N_OUT(rx_af_n),
    .PORT_A_ALMOST_EMPTY_FLAG_N_OUT(pa_ae_n));
  task automatic chk(input string nm, input logic [35:0] s, e);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  function automatic logic [17:0] pc(input logic [35:0] w, input int i,
    input logic bm, bg);
    int k;
    k = bg ? i : (bm ? 3 - i : 1 - i);
    pc = bm ? {9'h0, w[35 - 9 * k -: 9]} : w[35 - 18 * k -: 18];
  endfunction
  // Kinds: 0 port A write, 1 port A read, 2 receive, 3 transmit, 4 serial,
  // 5 port A write to the mailbox
  task automatic op(input int k, input logic [35:0] d);
    @(posedge clk);
    cs_n <= k > 1 && k < 5;
    en <= k < 2 || k > 4;
    dir <= k == 0 || k > 4;
    port_a_mailbox_select <= k > 4;
    rwe <= k == 2;
    tre <= k == 3;
    sle <= k == 4;
    pad <= d;
    rdat <= d[17:0];
    sdi <= d[0];
    @(posedge clk);
    cs_n <= 1'b1;
    en <= 1'b0;
    rwe <= 1'b0;
    tre <= 1'b0;
    sle <= 1'b0;
    port_a_mailbox_select <= 1'b0;
    @(negedge clk);
  endtask
  task automatic mreset(input logic bg, bm, input logic [1:0] md);
    @(posedge clk);
    ets <= bg;
    txw <= bm;
    rxw <= bm;
    mode <= md;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic wait_for(input int k);
    int n;
    for (n = 0; n < 40; n++) begin
      @(negedge clk);
      if (k == 0 && pa_rdy && rx_rdy && !receive_mailbox_select) break;
      if (k == 1 && tx_emp) break;
      if (k == 2 && pa_emp) break;
    end
    chk("flag wait", n < 40, 1'b1);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #250000;
    err_total++;
    report_and_stop();
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("ready at reset", pa_rdy, 1'b0);
    chk("empty at reset", tx_emp, 1'b0);
    $display("reset test done");
    for (r = 0; r < 4; r++) begin
      be = rows[r][19];
      b = rows[r][18];
      mreset(be, b, 2'h0);
      wait_for(0);
      op(0, LW);
      wait_for(1);
      for (i = 0; i < (b ? 4 : 2); i++) begin
        op(3, 36'h0);
        chk("tx", tx_q, i == 0 ? rows[r][17:0] : pc(LW, i, b, be));
      end
      for (i = 0; i < (b ? 4 : 2); i++) begin
        chk("pa empty", pa_emp, 1'b0);
        op(2, {18'h0, pc(LW, i, b, be) | (b ? 18'h3fe00 : 18'h0)});
      end
      wait_for(2);
      chk("inbound flags", {rx_af_n, pa_ae_n}, 2'b10);
      op(1, 36'h0);
      chk("pa data", pa_q, LW);
      chk("pa oe", oe, 1'b1);
      $display("row %0d done", r);
    end
    for (i = 0; i < 2; i++) begin
      op(0, LW);
      op(2, 36'h1);
      wait_for(1);
      @(posedge clk);
      ets <= i[0];
      part <= 1'b1;
      @(posedge clk);
      #1 chk("early drop", tx_emp, !i[0]);
      @(posedge clk);
      part <= 1'b0;
      #1 chk("late drop", tx_emp, 1'b0);
      wait_for(0);
    end
    for (i = 0; i < 4; i++) op(2, {18'h0, pc(LW, i, 1'b1, 1'b0)});
    wait_for(2);
    op(1, 36'h0);
    chk("after partial", pa_q, LW);
    $display("partial reset test done");
    for (m = 1; m < 3; m++) begin
      mreset(1'b1, 1'b0, m[1:0]);
      chk("ready in program", pa_rdy, 1'b0);
      for (i = 0; i < 20; i++) begin
        if (m == 1 && i == 0) op(5, 36'h1f);
        if (m == 1 && i < 4) op(0, (OFS >> (15 - 5 * i)) & 36'h1f);
        if (m == 2) op(4, OFS >> (19 - i));
      end
      wait_for(0);
      op(0, LW);
      op(0, LW);
      repeat (4) @(negedge clk);
      chk("almost empty", tx_ae_n, 1'b1);
      for (i = 0; i < 12; i++) op(0, LW);
      repeat (2) @(negedge clk);
      chk("almost full", pa_af_n, 1'b0);
      $display("offset mode %0d done", m);
    end
    report_and_stop();
  end
endmodule
